// ---- hdl/fsfl_consts.svh ----
// bit positions, classes and reset values of the status word logic
`ifndef FSFL_CONSTS_SVH
`define FSFL_CONSTS_SVH
`define FSFL_SW_W        16
`define FSFL_EXC_W       6
`define FSFL_BIT_INV     0
`define FSFL_BIT_SF      6
`define FSFL_BIT_ES      7
`define FSFL_BIT_C0      8
`define FSFL_BIT_C1      9
`define FSFL_BIT_C2      10
`define FSFL_BIT_TOP_LO  11
`define FSFL_BIT_TOP_HI  13
`define FSFL_BIT_C3      14
`define FSFL_BIT_B       15
`define FSFL_SW_RESET    16'h0000
`define FSFL_EXC_ZERO    6'h00
`define FSFL_TOP_ZERO    3'h0
`define FSFL_CLS_NONE    4'h0
`define FSFL_CLS_COMPARE 4'h1
`define FSFL_CLS_EXAMINE 4'h2
`define FSFL_CLS_PREM    4'h3
`define FSFL_CLS_TRIG    4'h4
`define FSFL_CLS_ARITH   4'h5
`define FSFL_CLS_LOAD    4'h6
`define FSFL_CLS_RESTORE 4'h7
`define FSFL_CLS_REINIT  4'h8
`define FSFL_CLS_CLEX    4'h9
`define FSFL_CC_W        4
`define FSFL_CC_C0       0
`define FSFL_CC_C1       1
`define FSFL_CC_C2       2
`define FSFL_CC_C3       3
`endif

// ---- hdl/fsfl_pkg.sv ----
// types of the status word logic
package fsfl_pkg;
   typedef struct packed {
      logic       c3;
      logic [2:0] top;
      logic       c2;
      logic       c1;
      logic       c0;
      logic       es;
      logic       sf;
      logic [5:0] exc;
   } fsfl_state_s;
endpackage

// ---- hdl/fsfl_status_word.sv ----
// status word update logic: condition codes, sticky flags, summary bits
// Contract
// RL1 - stack fault: cc one shows overflow/underflow
// RL2 - inexact result: cc one marks round-up
// RL3 - examine: sign to cc one, class elsewhere
// RL4 - remainder: cc two marks incomplete reduction
// RL5 - complete remainder: quotient bits into cc
// RL6 - trig: cc two marks source out of range
// RL7 - trig: cc one roundup or stack fault
// RL8 - compare: outcome in cc zero/two/three
// RL9 - load family: cc one zero or fault
// RL10 - restore/load env: all bits from image; es and bit 15 come from image flags and current masks
// RL11 - six sticky exception flags, bits 0-5
// RL12 - summary set by any unmasked flag
// RL13 - masked exception sets flag, not summary
// RL14 - flags held until clear/init/save/restore
// RL15 - bit 15 mirrors summary bit
// RL16 - stack fault flag at bit 6
// RL17 - invalid operand never clears stack fault
// RL18 - consumers ignore undefined cc bits
// RL19 - top pointer in bits 11-13
// RL20 - whole word readable for store-status
// RL21 - cc bits at architectural positions
// RL22 - init/save clears all flag bits at once
`timescale 1ns/1ps
`include "fsfl_consts.svh"
module fsfl_status_word (
   input  wire logic                     core_clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     instr_valid_in,
   input  wire logic [3:0]               instr_class_in,
   input  wire logic [`FSFL_EXC_W-1:0]   exc_detect_in,
   input  wire logic [`FSFL_EXC_W-1:0]   exc_mask_in,
   input  wire logic                     stack_fault_in,
   input  wire logic                     stack_overflow_in,
   input  wire logic                     round_up_in,
   input  wire logic                     cmp_c0_in,
   input  wire logic                     cmp_c2_in,
   input  wire logic                     cmp_c3_in,
   input  wire logic                     exam_sign_in,
   input  wire logic [2:0]               exam_class_in,
   input  wire logic                     prem_incomplete_in,
   input  wire logic [2:0]               prem_quotient_in,
   input  wire logic                     trig_out_of_range_in,
   input  wire logic [`FSFL_SW_W-1:0]    image_in,
   input  wire logic                     top_load_in,
   input  wire logic [2:0]               top_value_in,
   output logic      [`FSFL_SW_W-1:0]    fpu_status_word_out,
   output logic                          error_summary_out
);
   // reset word, split into fields by the function below
   localparam logic [`FSFL_SW_W-1:0] SW_RESET = `FSFL_SW_RESET;

   fsfl_pkg::fsfl_state_s   st_r;
   fsfl_pkg::fsfl_state_s   st_nxt;

   // class decode, already qualified by valid
   logic                    is_compare;
   logic                    is_examine;
   logic                    is_prem;
   logic                    is_trig;
   logic                    is_arith;
   logic                    is_load;
   logic                    is_restore;
   logic                    is_reinit;
   logic                    is_clex;
   logic                    flag_wipe;
   logic                    cc_idle;

   // flag paths
   logic [`FSFL_EXC_W-1:0]  exc_hit;
   logic [`FSFL_EXC_W-1:0]  exc_next;
   logic [`FSFL_EXC_W-1:0]  exc_live;
   logic                    sf_next;
   logic                    es_next;
   logic [2:0]              top_next;
   logic [`FSFL_SW_W-1:0]   sw_word;

   // condition code candidates, one per class
   logic                    c1_fault;
   logic                    c1_round;
   logic [`FSFL_CC_W-1:0]   cc_held;
   logic [`FSFL_CC_W-1:0]   cc_cmp;
   logic [`FSFL_CC_W-1:0]   cc_exam;
   logic [`FSFL_CC_W-1:0]   cc_prem;
   logic [`FSFL_CC_W-1:0]   cc_trig;
   logic [`FSFL_CC_W-1:0]   cc_arith;
   logic [`FSFL_CC_W-1:0]   cc_load;
   logic [`FSFL_CC_W-1:0]   cc_image;
   logic [`FSFL_CC_W-1:0]   cc_next;

   // unknown codes decode to nothing: flags still move, cc bits hold
   always_comb begin
      is_compare = 1'b0;
      is_examine = 1'b0;
      is_prem    = 1'b0;
      is_trig    = 1'b0;
      is_arith   = 1'b0;
      is_load    = 1'b0;
      is_restore = 1'b0;
      is_reinit  = 1'b0;
      is_clex    = 1'b0;
      if (instr_valid_in) begin
         unique case (instr_class_in)
            `FSFL_CLS_COMPARE: is_compare = 1'b1;
            `FSFL_CLS_EXAMINE: is_examine = 1'b1;
            `FSFL_CLS_PREM:    is_prem    = 1'b1;
            `FSFL_CLS_TRIG:    is_trig    = 1'b1;
            `FSFL_CLS_ARITH:   is_arith   = 1'b1;
            `FSFL_CLS_LOAD:    is_load    = 1'b1;
            `FSFL_CLS_RESTORE: is_restore = 1'b1;
            `FSFL_CLS_REINIT:  is_reinit  = 1'b1;
            `FSFL_CLS_CLEX:    is_clex    = 1'b1;
            default: begin
            end
         endcase
      end
   end

   // init/save and clear-exceptions both empty the sticky flags
   assign flag_wipe = is_reinit | is_clex; // RL14 RL22
   // clear-exc, class none and unknown codes leave the cc bits alone
   assign cc_idle   = ~(is_compare | is_examine | is_prem | is_trig | is_arith | is_load
                      | is_restore | is_reinit);

   // a clear and a detection in one cycle: the clear is the instruction, so it wins
   for (genvar g = 0; g < `FSFL_EXC_W; g = g + 1) begin : g_exc
      if (g == `FSFL_BIT_INV) begin : g_inv
         // a stack fault is also an invalid operation
         assign exc_hit[g] = instr_valid_in & (exc_detect_in[g] | stack_fault_in); // RL1
      end else begin : g_other
         assign exc_hit[g] = instr_valid_in & exc_detect_in[g]; // RL11
      end
      // restore overwrites the flag with the image bit
      assign exc_next[g] = flag_wipe  ? 1'b0                          // RL14
                         : is_restore ? image_in[g]                   // RL10
                         : (st_r.exc[g] | exc_hit[g]);                // RL11
      assign exc_live[g] = exc_next[g] & ~exc_mask_in[g]; // RL13
   end

   // invalid operand alone never lowers sf; only clear-exc, init or a restore image does
   always_comb begin
      if (flag_wipe) begin
         sf_next = 1'b0; // RL17 RL22
      end else if (is_restore) begin
         sf_next = image_in[`FSFL_BIT_SF];
      end else begin
         sf_next = st_r.sf | (instr_valid_in & stack_fault_in); // RL16
      end
   end

   // restore takes es from image flags and masks, not from image bit 7
   // summary follows new flags and present masks, so a mask change acts at the next clock edge
   assign es_next = |exc_live; // RL12

   // restore and init override a pointer load in the same cycle
   always_comb begin
      if (is_reinit) begin
         top_next = `FSFL_TOP_ZERO;
      end else if (is_restore) begin
         top_next = image_in[`FSFL_BIT_TOP_HI:`FSFL_BIT_TOP_LO];
      end else if (top_load_in) begin
         top_next = top_value_in; // RL19
      end else begin
         top_next = st_r.top;
      end
   end

   // a stack fault names over/underflow in cc one and outranks round-up
   always_comb begin
      c1_fault = 1'b0;
      c1_round = exc_detect_in[`FSFL_EXC_W-1] & round_up_in; // RL2
      if (stack_fault_in) begin
         c1_fault = stack_overflow_in; // RL1
         c1_round = stack_overflow_in;
      end
   end

   // undefined cc bits hold their last value
   assign cc_held = {st_r.c3, st_r.c2, st_r.c1, st_r.c0};

   // compare: outcome bits, cc one zero or fault
   always_comb begin
      cc_cmp              = cc_held;
      cc_cmp[`FSFL_CC_C0] = cmp_c0_in; // RL8
      cc_cmp[`FSFL_CC_C2] = cmp_c2_in;
      cc_cmp[`FSFL_CC_C3] = cmp_c3_in;
      cc_cmp[`FSFL_CC_C1] = c1_fault;
   end

   // examine: sign and operand class
   always_comb begin
      cc_exam              = cc_held;
      cc_exam[`FSFL_CC_C1] = exam_sign_in; // RL3
      cc_exam[`FSFL_CC_C0] = exam_class_in[0];
      cc_exam[`FSFL_CC_C2] = exam_class_in[1];
      cc_exam[`FSFL_CC_C3] = exam_class_in[2];
   end

   // incomplete reduction keeps cc zero and cc three of the last pass; cc one shows only a fault
   always_comb begin
      cc_prem              = cc_held;
      cc_prem[`FSFL_CC_C2] = prem_incomplete_in; // RL4
      cc_prem[`FSFL_CC_C1] = c1_fault;
      if (!prem_incomplete_in) begin
         cc_prem[`FSFL_CC_C0] = prem_quotient_in[2]; // RL5
         cc_prem[`FSFL_CC_C3] = prem_quotient_in[1];
         cc_prem[`FSFL_CC_C1] = stack_fault_in ? stack_overflow_in : prem_quotient_in[0];
      end
   end

   // cc one is undefined when out of range; round-up is still driven
   always_comb begin
      cc_trig              = cc_held;
      cc_trig[`FSFL_CC_C2] = trig_out_of_range_in; // RL6
      cc_trig[`FSFL_CC_C1] = c1_round; // RL7
   end

   // consumers must not rely on the held bits
   always_comb begin
      cc_arith              = cc_held;
      cc_arith[`FSFL_CC_C1] = c1_round; // RL2 RL18
   end

   // load family: only cc one is defined
   always_comb begin
      cc_load              = cc_held;
      cc_load[`FSFL_CC_C1] = c1_fault; // RL9
   end

   // restore or load env: every bit from the image
   always_comb begin
      cc_image              = cc_held;
      cc_image[`FSFL_CC_C0] = image_in[`FSFL_BIT_C0]; // RL10
      cc_image[`FSFL_CC_C1] = image_in[`FSFL_BIT_C1];
      cc_image[`FSFL_CC_C2] = image_in[`FSFL_BIT_C2];
      cc_image[`FSFL_CC_C3] = image_in[`FSFL_BIT_C3];
   end

   // one-hot decode lets the select be a plain and-or tree; init adds only zeros
   assign cc_next = ({`FSFL_CC_W{is_compare}} & cc_cmp)
                  | ({`FSFL_CC_W{is_examine}} & cc_exam)
                  | ({`FSFL_CC_W{is_prem}}    & cc_prem)
                  | ({`FSFL_CC_W{is_trig}}    & cc_trig)
                  | ({`FSFL_CC_W{is_arith}}   & cc_arith)
                  | ({`FSFL_CC_W{is_load}}    & cc_load)
                  | ({`FSFL_CC_W{is_restore}} & cc_image)
                  | ({`FSFL_CC_W{cc_idle}}    & cc_held); // RL22

   // every field has one source above; this block only packs them
   always_comb begin
      st_nxt     = st_r;
      st_nxt.exc = exc_next;
      st_nxt.sf  = sf_next;
      st_nxt.es  = es_next;
      st_nxt.top = top_next;
      st_nxt.c0  = cc_next[`FSFL_CC_C0];
      st_nxt.c1  = cc_next[`FSFL_CC_C1];
      st_nxt.c2  = cc_next[`FSFL_CC_C2];
      st_nxt.c3  = cc_next[`FSFL_CC_C3];
   end

   // field by field, so the state and the word cannot disagree in width
   function automatic fsfl_pkg::fsfl_state_s fpu_status_word_reset();
      fsfl_pkg::fsfl_state_s s;
      s.exc = SW_RESET[`FSFL_EXC_W-1:0];
      s.sf  = SW_RESET[`FSFL_BIT_SF];
      s.es  = SW_RESET[`FSFL_BIT_ES];
      s.c0  = SW_RESET[`FSFL_BIT_C0];
      s.c1  = SW_RESET[`FSFL_BIT_C1];
      s.c2  = SW_RESET[`FSFL_BIT_C2];
      s.top = SW_RESET[`FSFL_BIT_TOP_HI:`FSFL_BIT_TOP_LO];
      s.c3  = SW_RESET[`FSFL_BIT_C3];
      return s;
   endfunction

   // async clear to the reset word
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r <= fpu_status_word_reset();
      end else begin
         st_r <= st_nxt;
      end
   end

   // word built from named positions; b bit is a plain copy of the summary
   always_comb begin
      sw_word                                    = '0;
      sw_word[`FSFL_EXC_W-1:0]                   = st_r.exc; // RL11
      sw_word[`FSFL_BIT_SF]                      = st_r.sf; // RL16
      sw_word[`FSFL_BIT_ES]                      = st_r.es;
      sw_word[`FSFL_BIT_C0]                      = st_r.c0; // RL21
      sw_word[`FSFL_BIT_C1]                      = st_r.c1;
      sw_word[`FSFL_BIT_C2]                      = st_r.c2;
      sw_word[`FSFL_BIT_TOP_HI:`FSFL_BIT_TOP_LO] = st_r.top; // RL19
      sw_word[`FSFL_BIT_C3]                      = st_r.c3;
      sw_word[`FSFL_BIT_B]                       = st_r.es; // RL15
   end

   assign fpu_status_word_out = sw_word; // RL20
   assign error_summary_out   = st_r.es; // RL12
endmodule

// ---- dv/fsfl_assertions.sv ----
// status word assertions
`timescale 1ns/1ps
module fsfl_chk (
   input logic        core_clk_in,
   input logic        reset_n_in,
   input logic        instr_valid_in,
   input logic [3:0]  instr_class_in,
   input logic [5:0]  exc_mask_in,
   input logic        stack_fault_in,
   input logic [15:0] fpu_status_word_out,
   input logic        error_summary_out
);
   logic [15:0] w;
   logic        hold;
   assign w    = fpu_status_word_out;
   assign hold = !(instr_valid_in && instr_class_in inside {4'h7, 4'h8, 4'h9});
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   b_copy_a: assert property (w[15] == w[7]) else $error("b bit");
   es_port_a: assert property (error_summary_out == w[7]) else $error("es port");
   es_mask_a: assert property (w[7] == |(w[5:0] & ~$past(exc_mask_in)))
      else $error("es");
   flag_keep_a: assert property (hold |=> ($past(w[5:0]) & ~w[5:0]) == 6'h00)
      else $error("flags");
   sf_keep_a: assert property (hold && w[6] |=> w[6]) else $error("sf");
   sf_set_a: assert property (hold && instr_valid_in && stack_fault_in |=> w[6] && w[0])
      else $error("sf set");
   clr_exc_a: assert property (instr_valid_in && instr_class_in == 4'h9 |=> w[7:0] == 8'h00)
      else $error("clear");
   init_clr_a: assert property (instr_valid_in && instr_class_in == 4'h8 |=>
      {w[15:14], w[10:0]} == 13'h0000) else $error("init");
   restore_c: cover property (instr_valid_in && instr_class_in == 4'h7);
   fault_c: cover property (instr_valid_in && stack_fault_in);
   summary_c: cover property (w[7]);
endmodule
bind fsfl_status_word fsfl_chk chk (.core_clk_in, .reset_n_in, .instr_valid_in,
   .instr_class_in, .exc_mask_in, .stack_fault_in, .fpu_status_word_out, .error_summary_out);

// ---- dv/fsfl_pipe_model.sv ----
// pipeline model issuing completed instructions
`timescale 1ns/1ps
module fsfl_pipe_model (
   input  logic        clk_in,
   output logic [32:0] ins_out
);
   initial ins_out = 33'h0;
   // valid drops for a cycle so calls never collide; mask and image hold as levels
   task automatic issue(input logic [31:0] x);
      @(posedge clk_in);
      ins_out <= {1'b1, x};
      @(posedge clk_in);
      ins_out[32] <= 1'b0;
   endtask
endmodule

// ---- dv/fsfl_status_word_test.sv ----
// status word bench
`timescale 1ns/1ps
module fsfl_status_word_test;
   logic        core_clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic [32:0] p;
   logic [15:0] w;
   logic        es;
   logic        top_ld = 1'b0;
   logic [2:0]  top_v = 3'h0;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cyc = 0;
   always #12.5 core_clk_in = ~core_clk_in;
   fsfl_pipe_model pipe (.clk_in(core_clk_in), .ins_out(p));
   fsfl_status_word uut (.core_clk_in, .reset_n_in, .instr_valid_in(p[32]),
      .instr_class_in(p[31:28]), .exc_detect_in(p[27:22]), .exc_mask_in(p[21:16]),
      .stack_fault_in(p[0]), .stack_overflow_in(p[1]), .round_up_in(p[2]), .cmp_c0_in(p[3]),
      .cmp_c2_in(p[4]), .cmp_c3_in(p[5]), .exam_sign_in(p[6]), .exam_class_in(p[9:7]),
      .prem_incomplete_in(p[10]), .prem_quotient_in(p[13:11]), .trig_out_of_range_in(p[14]),
      .image_in(p[15:0]), .top_load_in(top_ld), .top_value_in(top_v), .fpu_status_word_out(w),
      .error_summary_out(es));
   task automatic chk(input string n, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // row: class, detect, mask, misc or image, compared bits, expected word
   task automatic run(input logic [67:0] t);
      pipe.issue({t[67:64], t[61:56], t[53:48], t[47:32]});
      #1;
      chk("status word", w & t[31:16], t[15:0]);
      chk("summary", {15'h0000, es & t[23]}, {15'h0000, t[7]});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      if (++cyc == 500) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      run(68'h5_20_00_0004_FFFF_82A0);
      run(68'h9_00_00_0000_80FF_0000);
      run(68'h5_04_3F_0000_80FF_0004);
      run(68'h1_00_3F_0028_C7FF_4104);
      run(68'h6_00_3F_0003_82FF_0245);
      run(68'h1_00_3F_0001_C7FF_0045);
      run(68'h0_00_3E_0000_80FF_80C5);
      run(68'h5_01_3E_0000_0040_0040);
      run(68'h2_00_3F_02C0_4700_4300);
      run(68'h3_00_3F_0400_0400_0400);
      run(68'h3_00_3F_3000_4700_4100);
      run(68'h4_00_3F_4000_0400_0400);
      run(68'h4_20_3F_0004_0600_0200);
      run(68'h7_00_3F_6D02_7FFF_6D02);
      run(68'h8_00_3F_0000_C7FF_0000);
      @(posedge core_clk_in);
      top_ld <= 1'b1;
      top_v  <= 3'h5;
      @(posedge core_clk_in);
      top_ld <= 1'b0;
      #1;
      chk("top pointer", {13'h0000, w[13:11]}, 16'h0005);
      end_sim();
   end
endmodule
